// file: spr_pkg.sv
package spr_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BAUD_RST = 9600;
  localparam int unsigned DIV_RST = (CLK_HZ + BAUD_RST / 2) / BAUD_RST;
  localparam int unsigned IDLE_MS = 10;
  localparam int unsigned IDLE_CYC = (CLK_HZ / 1000) * IDLE_MS;

  // sizes
  localparam int unsigned NPORT = 2;
  localparam int unsigned MSG_DEPTH = 16;
  localparam int unsigned DELIM_MAX = 4;
  localparam int unsigned IRQ_W = 3;

  // register offsets (port registers repeat at PORT_STRIDE)
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_NETP = 8'h08;
  localparam logic [7:0] OFS_PROTO = 8'h0c;
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [7:0] OFS_RCTL = 8'h20;
  localparam logic [7:0] OFS_DELIM = 8'h24;
  localparam logic [7:0] OFS_TMO = 8'h28;
  localparam logic [7:0] OFS_MLEN = 8'h2c;
  localparam logic [7:0] OFS_IST = 8'h30;
  localparam logic [7:0] OFS_ICLR = 8'h34;
  localparam logic [7:0] OFS_IEN = 8'h38;
  localparam logic [7:0] OFS_MSG = 8'h40;

  // field positions
  localparam int unsigned RCTL_EN = 0;
  localparam int unsigned RCTL_SEL = 1;
  localparam int unsigned RCTL_LEN = 2;
  localparam int unsigned IRQ_MSG = 0;
  localparam int unsigned IRQ_OVR = 1;

  // reset values
  localparam logic [15:0] NETP0_RST = 16'h1f41;
  localparam logic [15:0] NETP1_RST = 16'h1f42;
  localparam logic [31:0] DELIM_RST = 32'h0000_000d;
  localparam logic [2:0] DLEN_RST = 3'h1;

  typedef enum logic [2:0] {
    SPR_MODE_CTRL = 3'b001,
    SPR_MODE_BRIDGE = 3'b010,
    SPR_MODE_OFF = 3'b100
  } spr_mode_e;

  typedef enum logic [1:0] {SPR_RX_IDLE = 2'b01, SPR_RX_BUSY = 2'b10} spr_rx_e;
  typedef enum logic [1:0] {SPR_TX_IDLE = 2'b01, SPR_TX_BUSY = 2'b10} spr_tx_e;

  // byte toward the command interpreter
  typedef struct packed {
    logic port;
    logic proto;
    logic [7:0] data;
  } spr_cmd_s;

  // byte to or from a network socket
  typedef struct packed {
    logic [15:0] tcp_port;
    logic [7:0] data;
  } spr_net_s;

  // anything that is not a legal one-hot code counts as disconnected
  function automatic spr_mode_e spr_mode_dec(input logic [2:0] v);
    case (v)
      3'b001: spr_mode_dec = SPR_MODE_CTRL;
      3'b010: spr_mode_dec = SPR_MODE_BRIDGE;
      default: spr_mode_dec = SPR_MODE_OFF;
    endcase
  endfunction
endpackage

// file: spr_recog.sv
`timescale 1ns/100ps
module spr_recog import spr_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // settings
  input wire logic en,
  input wire logic [31:0] delim,
  input wire logic [2:0] delim_len,
  input wire logic [23:0] timeout,
  // incoming bytes
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  // last completed message
  output logic done,
  output logic [4:0] msg_len,
  output logic [8*MSG_DEPTH-1:0] msg_flat
);
  logic [7:0] acc_q [MSG_DEPTH];
  logic [7:0] acc_d [MSG_DEPTH];
  logic [7:0] msg_q [MSG_DEPTH];
  logic [7:0] msg_d [MSG_DEPTH];
  logic [4:0] cnt_q, cnt_d, len_q, len_d;
  logic [23:0] idle_q, idle_d;
  logic [31:0] tail_q, tail_d;
  logic done_q, done_d;

  // byte mask for a delimiter of n bytes, last byte in the low lane
  function automatic logic [31:0] dmask(input logic [2:0] n);
    dmask = 32'h0000_0000;
    for (int i = 0; i < DELIM_MAX; i++) begin
      if (i < n) dmask[8*i +: 8] = 8'hff;
    end
  endfunction

  // a full buffer also ends the message, so no byte is lost silently
  always_comb begin
    logic hit;
    hit = 1'b0;
    acc_d = acc_q;
    msg_d = msg_q;
    cnt_d = cnt_q;
    len_d = len_q;
    tail_d = tail_q;
    done_d = 1'b0;
    idle_d = (idle_q == 24'hff_ffff) ? idle_q : idle_q + 24'h00_0001;
    if (!en) begin
      cnt_d = 5'h00;
    end else if (in_valid) begin
      idle_d = 24'h00_0000;
      acc_d[cnt_q[3:0]] = in_data;
      tail_d = {tail_q[23:0], in_data};
      cnt_d = cnt_q + 5'h01;
      hit = (delim_len != 3'h0) && ({2'b00, delim_len} <= cnt_d)
        && (((tail_d ^ delim) & dmask(delim_len)) == 32'h0000_0000);
      if (hit || cnt_d == 5'(MSG_DEPTH)) begin
        msg_d = acc_d;
        len_d = cnt_d;
        cnt_d = 5'h00;
        done_d = 1'b1;
      end
    end else if (cnt_q != 5'h00 && idle_q >= timeout) begin
      msg_d = acc_d;
      len_d = cnt_q;
      cnt_d = 5'h00;
      done_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < MSG_DEPTH; i++) begin
        acc_q[i] <= 8'h00;
        msg_q[i] <= 8'h00;
      end
      cnt_q <= 5'h00;
      len_q <= 5'h00;
      idle_q <= 24'h00_0000;
      tail_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      msg_q <= msg_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      idle_q <= idle_d;
      tail_q <= tail_d;
      done_q <= done_d;
    end
  end

  // flatten the stored message, byte 0 in the low lane
  always_comb begin
    for (int i = 0; i < MSG_DEPTH; i++) msg_flat[8*i +: 8] = msg_q[i];
  end
  assign done = done_q;
  assign msg_len = len_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_done_nonempty;
    done_q |-> (len_q != 5'h00) && (cnt_q == 5'h00);
  endproperty
  a_done_nonempty: assert property (p_done_nonempty) else $error("empty message completed");

  property p_idle_timeout;
    (en && !in_valid && cnt_q != 5'h00 && idle_q >= timeout) |=> done_q && (len_q == $past(cnt_q));
  endproperty
  a_idle_timeout: assert property (p_idle_timeout) else $error("idle timeout missed");

  property p_idle_restart;
    (en && in_valid) |=> (idle_q == 24'h00_0000);
  endproperty
  a_idle_restart: assert property (p_idle_restart) else $error("idle timer not restarted");

  c_timeout_msg: cover property (en && !in_valid ##1 done_q);
endmodule // spr_recog

// file: spr_router.sv
// Operation
// - each port in exactly one of three modes
// - local and link ports hold separate modes
// - per-port baud rate, rate conversion built in
// - control mode feeds the command interpreter
// - bridge mode converts between socket and serial
// - socket number per port, local default 8001
// - bridge works alike on local and link port
// - disconnected port joins neither control nor bridge
// - collect bytes until delimiter or idle timeout
// - keep last message and raise an event
`timescale 1ns/100ps
module spr_router import spr_pkg::*; #(
  parameter int unsigned DIV_INIT = DIV_RST,
  parameter int unsigned TMO_INIT = IDLE_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // serial pins: local port and twisted-pair link channel
  input wire logic local_rxd,
  output logic local_txd,
  input wire logic link_rxd,
  output logic link_txd,
  // bytes to the command interpreter
  output logic cmd_valid,
  input wire logic cmd_ready,
  output spr_cmd_s cmd,
  // socket payload to serial
  input wire logic net_in_valid,
  output logic net_in_ready,
  input wire spr_net_s net_in,
  // serial payload to socket
  output logic net_out_valid,
  input wire logic net_out_ready,
  output spr_net_s net_out,
  // interrupt
  output logic irq
);
  // per-port settings
  logic [2:0] mode_q [NPORT];
  logic [2:0] mode_d [NPORT];
  logic [15:0] div_q [NPORT];
  logic [15:0] div_d [NPORT];
  logic [15:0] netp_q [NPORT];
  logic [15:0] netp_d [NPORT];
  logic [NPORT-1:0] proto_q, proto_d;
  // recognizer and interrupt registers
  logic [4:0] rctl_q, rctl_d;
  logic [31:0] delim_q, delim_d;
  logic [23:0] tmo_q, tmo_d;
  logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d, iclr, ev;
  // bus phase state
  logic act_q, act_d, wr_q, wr_d;
  logic [7:0] adr_q, adr_d;
  logic [31:0] rdata_q, rdata_d, rd_val;
  logic take;
  // datapath
  spr_mode_e mode [NPORT];
  logic [NPORT-1:0] rxd, txd, rx_v, tx_v, tx_rdy, hit, is_ctrl, is_brg;
  logic [7:0] rx_b [NPORT];
  logic [NPORT-1:0] pend_q, pend_d, pop;
  logic [7:0] pend_b_q [NPORT];
  logic [7:0] pend_b_d [NPORT];
  logic c_sel, n_sel, r_done;
  logic [4:0] r_len;
  logic [8*MSG_DEPTH-1:0] r_msg;

  assign take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1; // zero wait states, every access answers at once
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // mode decode: illegal codes fall back to disconnected
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      mode[i] = spr_mode_dec(mode_q[i]);
      is_ctrl[i] = (mode[i] == SPR_MODE_CTRL);
      is_brg[i] = (mode[i] == SPR_MODE_BRIDGE);
    end
  end

  // read mux, sampled in the address phase so hrdata comes from a flop
  always_comb begin
    logic [7:0] a;
    logic [7:0] f;
    a = haddr[7:0];
    f = a & ~PORT_STRIDE;
    rd_val = 32'h0000_0000;
    if (a < OFS_RCTL) begin
      if (f == OFS_MODE) rd_val = {29'h0, mode_q[a[4]]};
      else if (f == OFS_BAUD) rd_val = {16'h0000, div_q[a[4]]};
      else if (f == OFS_NETP) rd_val = {16'h0000, netp_q[a[4]]};
      else rd_val = {31'h0, proto_q[a[4]]};
    end else if (a == OFS_RCTL) rd_val = {27'h0, rctl_q};
    else if (a == OFS_DELIM) rd_val = delim_q;
    else if (a == OFS_TMO) rd_val = {8'h00, tmo_q};
    else if (a == OFS_MLEN) rd_val = {27'h0, r_len};
    else if (a == OFS_IST) rd_val = {29'h0, ist_q};
    else if (a == OFS_IEN) rd_val = {29'h0, ien_q};
    else if (a[7:4] == OFS_MSG[7:4]) rd_val = r_msg[32*a[3:2] +: 32];
  end

  // register writes land in the data phase
  always_comb begin
    logic [7:0] f;
    logic p;
    f = adr_q & ~PORT_STRIDE;
    p = adr_q[4];
    act_d = take;
    wr_d = hwrite;
    adr_d = haddr[7:0];
    rdata_d = (take && !hwrite) ? rd_val : rdata_q;
    mode_d = mode_q;
    div_d = div_q;
    netp_d = netp_q;
    proto_d = proto_q;
    rctl_d = rctl_q;
    delim_d = delim_q;
    tmo_d = tmo_q;
    ien_d = ien_q;
    iclr = '0;
    if (act_q && wr_q) begin
      if (adr_q < OFS_RCTL) begin
        if (f == OFS_MODE) mode_d[p] = hwdata[2:0];
        else if (f == OFS_BAUD) div_d[p] = hwdata[15:0];
        else if (f == OFS_NETP) netp_d[p] = hwdata[15:0];
        else proto_d[p] = hwdata[0];
      end else if (adr_q == OFS_RCTL) rctl_d = hwdata[4:0];
      else if (adr_q == OFS_DELIM) delim_d = hwdata;
      else if (adr_q == OFS_TMO) tmo_d = hwdata[23:0];
      else if (adr_q == OFS_ICLR) iclr = hwdata[IRQ_W-1:0];
      else if (adr_q == OFS_IEN) ien_d = hwdata[IRQ_W-1:0];
    end
    ist_d = (ist_q & ~iclr) | ev; // a new event beats a clear in the same cycle
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      mode_q[0] <= SPR_MODE_CTRL;
      mode_q[1] <= SPR_MODE_OFF;
      div_q[0] <= 16'(DIV_INIT);
      div_q[1] <= 16'(DIV_INIT);
      netp_q[0] <= NETP0_RST;
      netp_q[1] <= NETP1_RST;
      proto_q <= '0;
      rctl_q <= {DLEN_RST, 2'b00};
      delim_q <= DELIM_RST;
      tmo_q <= 24'(TMO_INIT);
      ist_q <= '0;
      ien_q <= '0;
    end else begin
      act_q <= act_d;
      wr_q <= wr_d;
      adr_q <= adr_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      div_q <= div_d;
      netp_q <= netp_d;
      proto_q <= proto_d;
      rctl_q <= rctl_d;
      delim_q <= delim_d;
      tmo_q <= tmo_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
    end
  end

  assign irq = |(ist_q & ien_q);
  assign rxd = {link_rxd, local_rxd};
  assign local_txd = txd[0];
  assign link_txd = txd[1];

  // one uart per port, each on its own divisor; bytes cross at byte level
  // so differing rates need no further conversion
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    spr_uart u_uart (
      .hclk(hclk),
      .hresetn(hresetn),
      .div(div_q[g]),
      .rxd(rxd[g]),
      .rx_valid(rx_v[g]),
      .rx_data(rx_b[g]),
      .txd(txd[g]),
      .tx_valid(tx_v[g]),
      .tx_ready(tx_rdy[g]),
      .tx_data(net_in.data)
    );
  end

  // socket to serial: the port whose number matches and is bridging takes it
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      hit[i] = is_brg[i] && (net_in.tcp_port == netp_q[i]);
    end
    tx_v[0] = net_in_valid && hit[0];
    tx_v[1] = net_in_valid && hit[1] && !hit[0];
    // unmatched payload is swallowed so the socket side never hangs
    net_in_ready = hit[0] ? tx_rdy[0] : (hit[1] ? tx_rdy[1] : 1'b1);
  end

  // serial to interpreter or socket; one byte held per port, local first
  always_comb begin
    c_sel = !(pend_q[0] && is_ctrl[0]);
    n_sel = !(pend_q[0] && is_brg[0]);
    cmd_valid = |(pend_q & is_ctrl);
    cmd = '{port: c_sel, proto: proto_q[c_sel], data: pend_b_q[c_sel]};
    net_out_valid = |(pend_q & is_brg);
    net_out = '{tcp_port: netp_q[n_sel], data: pend_b_q[n_sel]};
    pop = '0;
    if (cmd_valid && cmd_ready) pop[c_sel] = 1'b1;
    if (net_out_valid && net_out_ready) pop[n_sel] = 1'b1;
    pend_d = pend_q & ~pop & ~(~(is_ctrl | is_brg));
    pend_b_d = pend_b_q;
    ev = '0;
    for (int i = 0; i < NPORT; i++) begin
      if (rx_v[i] && (is_ctrl[i] || is_brg[i])) begin
        if (pend_q[i] && !pop[i]) begin
          ev[IRQ_OVR + i] = 1'b1; // held byte kept, newcomer dropped
        end else begin
          pend_d[i] = 1'b1;
          pend_b_d[i] = rx_b[i];
        end
      end
    end
    ev[IRQ_MSG] = r_done;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= '0;
      pend_b_q[0] <= 8'h00;
      pend_b_q[1] <= 8'h00;
    end else begin
      pend_q <= pend_d;
      pend_b_q <= pend_b_d;
    end
  end

  // recognizer listens to the selected port whatever its mode
  spr_recog u_recog (
    .hclk(hclk),
    .hresetn(hresetn),
    .en(rctl_q[RCTL_EN]),
    .delim(delim_q),
    .delim_len(rctl_q[RCTL_LEN +: 3]),
    .timeout(tmo_q),
    .in_valid(rx_v[rctl_q[RCTL_SEL]]),
    .in_data(rx_b[rctl_q[RCTL_SEL]]),
    .done(r_done),
    .msg_len(r_len),
    .msg_flat(r_msg)
  );

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_mode_onehot;
    $onehot({is_ctrl[0], is_brg[0], mode[0] == SPR_MODE_OFF})
      && $onehot({is_ctrl[1], is_brg[1], mode[1] == SPR_MODE_OFF});
  endproperty
  a_mode_onehot: assert property (p_mode_onehot) else $error("port mode not unique");

  property p_mode_separate;
    (act_q && wr_q && adr_q == OFS_MODE) |=> $stable(mode_q[1]);
  endproperty
  a_mode_separate: assert property (p_mode_separate) else $error("link mode disturbed");

  property p_cmd_ctrl;
    cmd_valid |-> is_ctrl[cmd.port] && pend_q[cmd.port] && cmd.proto == proto_q[cmd.port];
  endproperty
  a_cmd_ctrl: assert property (p_cmd_ctrl) else $error("command byte from wrong mode");

  property p_net_brg;
    net_out_valid |-> is_brg[n_sel] && net_out.tcp_port == netp_q[n_sel];
  endproperty
  a_net_brg: assert property (p_net_brg) else $error("socket byte from wrong mode");

  property p_tx_local;
    (net_in_valid && net_in_ready && hit[0]) |=> !tx_rdy[0] ##0 !local_txd;
  endproperty
  a_tx_local: assert property (p_tx_local) else $error("local port did not transmit");

  property p_tx_link;
    (net_in_valid && net_in_ready && hit[1] && !hit[0]) |=> !tx_rdy[1] ##0 !link_txd;
  endproperty
  a_tx_link: assert property (p_tx_link) else $error("link port did not transmit");

  property p_off_silent;
    (mode[0] == SPR_MODE_OFF) |-> !tx_v[0] ##1 (!pend_q[0] || mode[0] != SPR_MODE_OFF);
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("disconnected port active");

  property p_msg_event;
    r_done |=> ist_q[IRQ_MSG] ##0 (irq == ien_q[IRQ_MSG] || |(ist_q & ien_q));
  endproperty
  a_msg_event: assert property (p_msg_event) else $error("message event lost");

  c_cmd: cover property (cmd_valid && cmd_ready);
  c_bridge_out: cover property (net_out_valid && net_out_ready);
  c_bridge_in: cover property (net_in_valid && net_in_ready && hit[1]);
  c_irq: cover property ($rose(irq));
endmodule // spr_router

// file: spr_serial_eq.sv
`timescale 1ns/100ps
// serial equipment on the far side: 8n1, lsb first, line idles high
module spr_serial_eq (
  // clock and bit time
  input wire logic clk,
  input wire logic [15:0] div,
  // line into the device, line out of it
  output logic line,
  input wire logic din
);
  logic [7:0] got;
  int cnt = 0;
  initial line = 1'b1;
  // frames sent back to back leave no idle gap between bytes
  task send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line <= f[i];
      repeat (div - 1) @(posedge clk);
    end
  endtask
  // sample on the falling edge, clear of the edge that launches txd
  always begin
    @(negedge din);
    repeat (div / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(negedge clk);
      got[i] = din;
    end
    repeat (div) @(negedge clk);
    cnt++;
  end
endmodule // spr_serial_eq

// file: spr_uart.sv
`timescale 1ns/100ps
module spr_uart import spr_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bit time in clock cycles
  input wire logic [15:0] div,
  // receive side
  input wire logic rxd,
  output logic rx_valid,
  output logic [7:0] rx_data,
  // transmit side
  output logic txd,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data
);
  spr_rx_e rx_st_q, rx_st_d;
  logic [15:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic rx_v_q, rx_v_d;
  logic [7:0] rx_dat_q, rx_dat_d;
  spr_tx_e tx_st_q, tx_st_d;
  logic [15:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [8:0] tx_sh_q, tx_sh_d;
  logic txd_q, txd_d;

  // receiver: 8N1, sample in mid bit, a start bit that is gone by then is noise
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_v_d = 1'b0;
    rx_dat_d = rx_dat_q;
    unique case (rx_st_q)
      SPR_RX_IDLE: begin
        if (!rxd) begin
          rx_st_d = SPR_RX_BUSY;
          rx_cnt_d = {1'b0, div[15:1]};
          rx_bit_d = 4'h0;
        end
      end
      SPR_RX_BUSY: begin
        if (rx_cnt_q != 16'h0000) begin
          rx_cnt_d = rx_cnt_q - 16'h0001;
        end else begin
          rx_cnt_d = div - 16'h0001;
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0) begin
            if (rxd) rx_st_d = SPR_RX_IDLE;
          end else if (rx_bit_q <= 4'h8) begin
            rx_sh_d = {rxd, rx_sh_q[7:1]};
          end else begin
            rx_st_d = SPR_RX_IDLE;
            rx_v_d = rxd; // framing error drops the byte
            rx_dat_d = rx_sh_q;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q <= SPR_RX_IDLE;
      rx_cnt_q <= 16'h0000;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      rx_v_q <= 1'b0;
      rx_dat_q <= 8'h00;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_v_q <= rx_v_d;
      rx_dat_q <= rx_dat_d;
    end
  end

  // transmitter: start bit goes out at once, then 8 data bits and the stop bit
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    txd_d = txd_q;
    unique case (tx_st_q)
      SPR_TX_IDLE: begin
        if (tx_valid) begin
          tx_st_d = SPR_TX_BUSY;
          tx_sh_d = {1'b1, tx_data};
          tx_bit_d = 4'h9;
          tx_cnt_d = div - 16'h0001;
          txd_d = 1'b0;
        end
      end
      SPR_TX_BUSY: begin
        if (tx_cnt_q != 16'h0000) begin
          tx_cnt_d = tx_cnt_q - 16'h0001;
        end else if (tx_bit_q == 4'h0) begin
          tx_st_d = SPR_TX_IDLE;
          txd_d = 1'b1;
        end else begin
          txd_d = tx_sh_q[0];
          tx_sh_d = {1'b1, tx_sh_q[8:1]};
          tx_bit_d = tx_bit_q - 4'h1;
          tx_cnt_d = div - 16'h0001;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_q <= SPR_TX_IDLE;
      tx_cnt_q <= 16'h0000;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h1ff;
      txd_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      txd_q <= txd_d;
    end
  end

  assign rx_valid = rx_v_q;
  assign rx_data = rx_dat_q;
  assign txd = txd_q;
  assign tx_ready = (tx_st_q == SPR_TX_IDLE);
endmodule // spr_uart

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import spr_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, cmd_ready = 0, net_out_ready = 0;
  logic net_in_valid = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, seed = 32'h0000_0014;
  logic [15:0] ldiv = 16'h0008;
  logic [7:0] b;
  spr_net_s net_in = '0;
  wire logic hreadyout, hresp, local_rxd, local_txd, link_rxd, link_txd, irq;
  wire logic cmd_valid, net_in_ready, net_out_valid;
  wire logic [31:0] hrdata;
  spr_cmd_s cmd;
  spr_net_s net_out;
  int errors = 0, compares = 0, n, c0;
  // short bit time and idle count keep the run brief
  spr_router #(.DIV_INIT(8), .TMO_INIT(50)) spr_router_inst (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .local_rxd, .local_txd, .link_rxd, .link_txd, .cmd_valid, .cmd_ready, .cmd,
    .net_in_valid, .net_in_ready, .net_in, .net_out_valid, .net_out_ready, .net_out, .irq);
  spr_serial_eq local_eq (.clk(hclk), .div(16'h0008), .line(local_rxd), .din(local_txd));
  spr_serial_eq link_eq (.clk(hclk), .div(ldiv), .line(link_rxd), .din(link_txd));
  always #4 hclk = ~hclk;
  function logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one single ahb-lite transfer; read data taken at the edge ending the data phase
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task net_send(input logic [15:0] p, input logic [7:0] d);
    @(posedge hclk);
    net_in_valid <= 1'b1;
    net_in <= '{p, d};
    @(posedge hclk);
    while (net_in_ready !== 1'b1) @(posedge hclk);
    net_in_valid <= 1'b0;
  endtask
  // bounded waits; the #1 lets the edge's updates land before looking
  task wait_out;
    for (n = 0; n < 400 && cmd_valid !== 1'b1 && net_out_valid !== 1'b1; n++) @(posedge hclk);
    #1;
  endtask
  // ready is held low so a byte stands until it is checked; one pulse releases it
  task pop;
    @(posedge hclk);
    cmd_ready <= 1'b1;
    net_out_ready <= 1'b1;
    @(posedge hclk);
    cmd_ready <= 1'b0;
    net_out_ready <= 1'b0;
  endtask
  task wait_rx(input bit lk);
    for (n = 0; n < 400 && (lk ? link_eq.cnt : local_eq.cnt) == c0; n++) @(posedge hclk);
  endtask
  task final_report;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the whole sequence needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, OFS_MODE, 0); chk(rd, 1, "mode0");
    bus(0, OFS_MODE + PORT_STRIDE, 0); chk(rd, 4, "mode1");
    bus(0, OFS_NETP, 0); chk(rd, 32'h0000_1f41, "netp0");
    bus(0, 8'hfc, 0); chk(rd, 0, "unmapped");
    chk({hresp, hreadyout}, 1, "okay");
    $display("test reset done");
    b = xs();
    bus(1, OFS_PROTO, {31'h0, b[0]});
    local_eq.send(b); wait_out; chk({cmd_valid, cmd}, {2'b10, b[0], b}, "ctrl");
    pop;
    bus(1, OFS_PROTO, 0);
    $display("test control done");
    bus(1, OFS_MODE, 2); c0 = local_eq.cnt; b = xs();
    net_send(16'h1f41, b); wait_rx(0); chk(local_eq.got, b, "local tx");
    b = xs();
    local_eq.send(b); wait_out;
    chk({cmd_valid, net_out_valid, net_out}, {2'b01, 16'h1f41, b}, "local rx");
    pop;
    $display("test local bridge done");
    // an illegal mode code must behave as disconnected
    bus(1, OFS_MODE + PORT_STRIDE, 7); c0 = link_eq.cnt;
    net_send(16'h1f42, b); link_eq.send(b); wait_out;
    chk({cmd_valid, net_out_valid, 30'(link_eq.cnt - c0)}, 0, "off");
    $display("test off done");
    bus(1, OFS_MODE + PORT_STRIDE, 2); bus(1, OFS_BAUD + PORT_STRIDE, 16); ldiv = 16;
    c0 = link_eq.cnt; b = xs();
    net_send(16'h1f42, b); wait_rx(1); chk(link_eq.got, b, "link tx");
    b = xs();
    link_eq.send(b); wait_out;
    chk({net_out_valid, net_out}, {1'b1, 16'h1f42, b}, "link rx");
    pop;
    $display("test link bridge done");
    // idle limit above the 80-cycle byte spacing, so only the delimiter ends it
    bus(1, OFS_MODE, 1); bus(1, OFS_TMO, 200); bus(1, OFS_RCTL, 32'h0000_0005);
    b = xs() | 8'h80;
    local_eq.send(b); local_eq.send(8'h0d); repeat (20) @(posedge hclk);
    chk(irq, 0, "masked");
    bus(0, OFS_IST, 0); chk(rd[0], 1, "ist");
    bus(1, OFS_IEN, 1); #1; chk(irq, 1, "irq");
    bus(0, OFS_MLEN, 0); chk(rd, 2, "mlen");
    bus(0, OFS_MSG, 0); chk(rd & 32'h0000_ffff, {16'h0, 8'h0d, b}, "msg");
    bus(1, OFS_ICLR, 1); #1; chk(irq, 0, "clear");
    $display("test delimiter done");
    local_eq.send(xs()); repeat (150) @(posedge hclk);
    bus(0, OFS_IST, 0); chk(rd[0], 0, "early");
    repeat (100) @(posedge hclk);
    bus(0, OFS_MLEN, 0); chk({irq, rd[30:0]}, {1'b1, 31'h1}, "timeout");
    $display("test timeout done");
    final_report;
  end
endmodule // tb_top
